// >>> ppc_device.sv
// Purpose: controller end, decodes host strobes and runs commands
// Assumes: strobes synchronous to clk_i; mechanism acknowledges with mech_done_i
// Notes: printer solenoid and feed timing sits behind mech_req_o
// Behaviour
// - write with cd high is a command
// - write with cd low stores a character
// - read gives controller or printer status
// - both strobes inhibit; deselect floats the bus
// - direction flag: 1 host writes, 0 reads
// - printer status read sets direction back
// - busy flag while an operation runs
// - ready flag when latched status waits
// - host checks busy before each operation; ppc_host polls busy only before writes requested with check_i
// - printer status low nibble holds sensors
// - initialize blanks buffer, moves head
// - status request locks commands until read
// - format command sets column layout
// - pointer increment stays within its half
// - print then blank; nothing else meanwhile
// - single-station print: feed and slip flags
// - dual-station print: station select field
// - dual-station print: journal, receipt feed flags
// - fast feed counts feeds then blanks
// - fast feed follow-up action field
// - character stored at pointer, pointer advances
// - host leaves 1 us between accesses
// - reset: pointer left, capacity 40 columns
//
`timescale 1ns/1ps
module ppc_device
  import ppc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // host bus
  ppc_bus_if.dev bus,
  // printer sensors
  input wire logic head_left_i,
  input wire logic low_paper_i,
  input wire logic left_sense_i,
  input wire logic right_sense_i,
  // mechanism handshake
  output logic mech_req_o,
  output ppc_mop_t mech_op_o,
  input wire logic mech_done_i,
  output logic head_left_o,
  output logic [1:0] column_format_field_o,
  output logic [1:0] station_select_o,
  output logic line_feed_after_print_o,
  output logic slip_release_after_print_o,
  output logic journal_feed_after_print_o,
  output logic receipt_feed_after_print_o,
  output logic [1:0] fast_feed_followup_o,
  output logic [3:0] step_count_o,
  // column buffer read port for the mechanism
  input wire logic [5:0] col_addr_i,
  output logic [6:0] col_data_o
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_MECH = 2'b10} ppc_dev_st_t;
  typedef struct packed {
    ppc_dev_st_t st;
    logic dir;
    logic ready;
    logic [3:0] sens;
    logic [1:0] fmt;
    logic [5:0] ptr;
    logic wr_act;
    logic wr_cd;
    logic wr_inh;
    logic [7:0] wr_data;
    logic rd_act;
    logic rd_cd;
    logic rd_inh;
    logic [7:0] rd_data;
    logic head_left;
    ppc_mop_t op;
    logic [1:0] station;
    logic lf;
    logic sr;
    logic journal_feed_after_print;
    logic receipt_feed_after_print;
    logic [1:0] followup;
    logic [3:0] steps;
    logic [6:0] col_data;
  } ppc_dev_state_t;
  ppc_dev_state_t s_reg;
  ppc_dev_state_t s_next;
  logic [6:0] buf_mem [BUF_DEPTH];
  logic blank_all;
  logic mem_we;
  logic busy;
  logic [5:0] half_end;
  logic [6:0] incr_sum;
  logic [7:0] cmd;
  // ****************************************
  // helpers
  // ****************************************
  // busy is the machine state itself, so it can never disagree with it
  assign busy = (s_reg.st == ST_MECH);
  assign cmd = s_reg.wr_data;
  assign incr_sum = {1'b0, s_reg.ptr} + {3'h0, cmd[3:0]};
  // end of the region the pointer lives in
  always_comb
  begin
    unique case (s_reg.fmt)
      FMT_TWIN: half_end = COLS_HALF;
      FMT_SPLIT: half_end = (s_reg.ptr < COLS_HALF) ? COLS_HALF : COLS_SPLIT;
      default: half_end = COLS_WIDE;
    endcase
  end
  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_next = s_reg;
    blank_all = 1'b0;
    mem_we = 1'b0;
    // status byte prepared a cycle ahead so the bus data is from a flop
    if (bus.cd)
    begin
      s_next.rd_data = {5'h00, s_reg.dir, busy, s_reg.ready};
    end
    else
    begin
      s_next.rd_data = {4'h0, s_reg.sens};
    end
    s_next.col_data = buf_mem[col_addr_i];
    // read strobe: act at its trailing edge
    if (!bus.cs_n && !bus.rd_n)
    begin
      s_next.rd_act = 1'b1;
      s_next.rd_cd = bus.cd;
      if (!bus.wr_n)
      begin
        s_next.rd_inh = 1'b1;
      end
    end
    else if (s_reg.rd_act)
    begin
      if (!s_reg.rd_cd && !s_reg.rd_inh)
      begin
        s_next.dir = 1'b1;
        s_next.ready = 1'b0;
      end
      s_next.rd_act = 1'b0;
      s_next.rd_inh = 1'b0;
    end
    // write strobe: data kept while low, acted on when released
    if (!bus.cs_n && !bus.wr_n)
    begin
      s_next.wr_act = 1'b1;
      s_next.wr_cd = bus.cd;
      s_next.wr_data = bus.data;
      if (!bus.rd_n)
      begin
        s_next.wr_inh = 1'b1;
      end
    end
    else if (s_reg.wr_act)
    begin
      s_next.wr_act = 1'b0;
      s_next.wr_inh = 1'b0;
      if (!s_reg.wr_inh && !busy)
      begin
        if (!s_reg.wr_cd)
        begin
          // writes past the region end are dropped, pointer parks there
          if (s_reg.ptr < half_end)
          begin
            mem_we = 1'b1;
            s_next.ptr = s_reg.ptr + 6'h01;
          end
        end
        else if (!s_reg.ready)
        begin
          if (cmd[7:5] == CMD_INIT)
          begin
            s_next.head_left = cmd[4];
            s_next.fmt = FMT_WIDE;
            s_next.ptr = 6'h00;
            blank_all = 1'b1;
            s_next.op = MOP_INIT;
            s_next.st = ST_MECH;
          end
          else if (cmd[7:5] == CMD_STATUS)
          begin
            s_next.sens = {head_left_i, low_paper_i, left_sense_i, right_sense_i};
            s_next.ready = 1'b1;
            s_next.dir = 1'b0;
          end
          else if (cmd[7:4] == CMD_INCR)
          begin
            if (s_reg.ptr < half_end)
            begin
              s_next.ptr = (incr_sum >= {1'b0, half_end}) ? half_end - 6'h01
                                                          : incr_sum[5:0];
            end
          end
          else if (cmd[7:6] == CMD_FORMAT)
          begin
            s_next.fmt = cmd[5:4];
            s_next.ptr = 6'h00;
          end
          else if (cmd[7:6] == CMD_PRINT)
          begin
            s_next.station = cmd[5:4];
            s_next.journal_feed_after_print = cmd[3];
            s_next.receipt_feed_after_print = cmd[2];
            s_next.lf = cmd[2];
            s_next.sr = cmd[0];
            s_next.op = MOP_PRINT;
            s_next.st = ST_MECH;
          end
          else
          begin
            s_next.followup = cmd[5:4];
            s_next.steps = cmd[3:0];
            s_next.op = MOP_FEED;
            s_next.st = ST_MECH;
          end
        end
      end
    end
    // mechanism finished: print and feed leave a blank buffer
    if (busy && mech_done_i)
    begin
      s_next.st = ST_IDLE;
      if (s_reg.op != MOP_INIT)
      begin
        blank_all = 1'b1;
        s_next.ptr = 6'h00;
      end
    end
  end
  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.dir <= RST_DIR;
      s_reg.ready <= RST_READY;
      s_reg.fmt <= FMT_WIDE;
      s_reg.ptr <= 6'h00;
      s_reg.op <= MOP_INIT;
    end
    else
    begin
      s_reg <= s_next;
    end
  end
  // column buffer, blanked whole in one edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i || blank_all)
    begin
      for (int i = 0; i < BUF_DEPTH; i++)
      begin
        buf_mem[i] <= BLANK_CHAR;
      end
    end
    else if (mem_we)
    begin
      buf_mem[s_reg.ptr] <= s_reg.wr_data[6:0];
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  // drive only for a clean read; deselect or overlap floats the bus
  assign bus.dev_doe = !bus.cs_n && !bus.rd_n && bus.wr_n;
  assign bus.dev_dout = s_reg.rd_data;
  assign mech_req_o = busy;
  assign mech_op_o = s_reg.op;
  assign head_left_o = s_reg.head_left;
  assign column_format_field_o = s_reg.fmt;
  assign station_select_o = s_reg.station;
  assign line_feed_after_print_o = s_reg.lf;
  assign slip_release_after_print_o = s_reg.sr;
  assign journal_feed_after_print_o = s_reg.journal_feed_after_print;
  assign receipt_feed_after_print_o = s_reg.receipt_feed_after_print;
  assign fast_feed_followup_o = s_reg.followup;
  assign step_count_o = s_reg.steps;
  assign col_data_o = s_reg.col_data;
endmodule : ppc_device

// >>> ppc_pkg.sv
// Purpose: shared constants and types of the printer controller host port
// Assumes: 20 MHz system clock on both ends
// Notes: status bit positions and command top bits live here; ppc_device slices the other command fields itself
package ppc_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 50;
  localparam int STB_NS = 250; // least strobe width
  localparam int RV_NS = 1000; // least recovery between accesses
  localparam int STB_CYC = (STB_NS + CLK_NS - 1) / CLK_NS;
  localparam int RV_CYC = (RV_NS + CLK_NS - 1) / CLK_NS;
  // ****************************************
  // column buffer
  // ****************************************
  localparam logic [6:0] BLANK_CHAR = 7'h20;
  localparam int BUF_DEPTH = 40;
  localparam logic [5:0] COLS_WIDE = 6'h28;
  localparam logic [5:0] COLS_HALF = 6'h12;
  localparam logic [5:0] COLS_SPLIT = 6'h24;
  localparam logic [1:0] FMT_WIDE = 2'h0;
  localparam logic [1:0] FMT_TWIN = 2'h1;
  localparam logic [1:0] FMT_SPLIT = 2'h2;
  // ****************************************
  // status bit positions and reset values
  // ****************************************
  localparam int ST_DIR_BIT = 2;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_READY_BIT = 0;
  localparam logic RST_DIR = 1'b1;
  localparam logic RST_READY = 1'b0;
  // ****************************************
  // command top bits
  // ****************************************
  localparam logic [2:0] CMD_INIT = 3'h0;
  localparam logic [2:0] CMD_STATUS = 3'h1;
  localparam logic [3:0] CMD_INCR = 4'h7;
  localparam logic [1:0] CMD_FORMAT = 2'h1;
  localparam logic [1:0] CMD_PRINT = 2'h2;
  localparam logic [1:0] CMD_FEED = 2'h3;
  // mechanism operations
  typedef enum logic [1:0] {MOP_INIT = 2'h0, MOP_PRINT = 2'h1, MOP_FEED = 2'h2} ppc_mop_t;
endpackage : ppc_pkg

// >>> ppc_bus_if.sv
// Purpose: strobed 8-bit host bus between host end and controller end
// Assumes: all pins synchronous to the shared clock
// Notes: bus reads FF when nobody drives it
`timescale 1ns/1ps
interface ppc_bus_if;
  logic cs_n;
  logic cd;
  logic rd_n;
  logic wr_n;
  logic [7:0] host_dout;
  logic host_doe;
  logic [7:0] dev_dout;
  logic dev_doe;
  logic [7:0] data;
  // resolved data bus level
  assign data = host_doe ? host_dout : (dev_doe ? dev_dout : 8'hFF);
  modport dev (input cs_n, input cd, input rd_n, input wr_n, input data,
               output dev_dout, output dev_doe);
  modport host (output cs_n, output cd, output rd_n, output wr_n,
                output host_dout, output host_doe, input data);
endinterface : ppc_bus_if

// >>> ppc_host.sv
// Purpose: host end, turns user requests into timed bus strobes
// Assumes: one request at a time, req_i high for a single cycle while idle
// Notes: optional busy poll before writes
`timescale 1ns/1ps
module ppc_host
  import ppc_pkg::*;
#(
  parameter int STROBE_CYC = STB_CYC,
  parameter int GAP_CYC = RV_CYC
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // host bus
  ppc_bus_if.host bus,
  // user request
  input wire logic req_i,
  input wire logic rd_i,
  input wire logic cd_i,
  input wire logic check_i,
  input wire logic [7:0] wdata_i,
  // user answer
  output logic ack_o,
  output logic busy_o,
  output logic [7:0] rdata_o
);
  // ****************************************
  // parameter check
  // ****************************************
  if (STROBE_CYC < STB_CYC || STROBE_CYC > 63 || GAP_CYC < RV_CYC || GAP_CYC > 63)
  begin : g_bad
    $error("ppc_host: strobe or gap count out of range");
  end
  localparam logic [5:0] STB_LAST = 6'(STROBE_CYC - 1);
  localparam logic [5:0] GAP_LAST = 6'(GAP_CYC - 1);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {H_IDLE = 3'b001, H_STRB = 3'b010, H_GAP = 3'b100} ppc_host_st_t;
  typedef struct packed {
    ppc_host_st_t st;
    logic cs_n;
    logic cd;
    logic rd_n;
    logic wr_n;
    logic [7:0] dout;
    logic doe;
    logic [5:0] cnt;
    logic poll;
    logic pend;
    logic op_rd;
    logic op_cd;
    logic [7:0] op_data;
    logic [7:0] rdata;
    logic ack;
  } ppc_host_state_t;
  ppc_host_state_t s_reg;
  ppc_host_state_t s_next;
  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.cnt = s_reg.cnt + 6'h01;
    unique case (s_reg.st)
      H_IDLE:
      begin
        if (req_i)
        begin
          s_next.op_rd = rd_i;
          s_next.op_cd = cd_i;
          s_next.op_data = wdata_i;
          s_next.pend = 1'b1;
          s_next.poll = !rd_i && check_i;
          s_next.cnt = 6'h00;
          s_next.st = H_GAP;
          s_next.cnt = GAP_LAST; // start the strobe on the next edge
        end
      end
      H_STRB:
      begin
        if (s_reg.cnt == STB_LAST)
        begin
          s_next.cs_n = 1'b1;
          s_next.rd_n = 1'b1;
          s_next.wr_n = 1'b1;
          s_next.doe = 1'b0;
          if (s_reg.poll)
          begin
            s_next.poll = bus.data[ST_BUSY_BIT];
          end
          else
          begin
            s_next.rdata = bus.data;
            s_next.pend = 1'b0;
          end
          s_next.cnt = 6'h00;
          s_next.st = H_GAP;
        end
      end
      default:
      begin
        // recovery spacing before the next strobe or the answer
        if (s_reg.cnt == GAP_LAST)
        begin
          s_next.cnt = 6'h00;
          if (!s_reg.pend)
          begin
            s_next.ack = 1'b1;
            s_next.st = H_IDLE;
          end
          else
          begin
            s_next.st = H_STRB;
            s_next.cs_n = 1'b0;
            s_next.cd = s_reg.poll ? 1'b1 : s_reg.op_cd;
            // never both strobes at once, that would be inhibited
            s_next.rd_n = !(s_reg.poll || s_reg.op_rd);
            s_next.wr_n = s_reg.poll || s_reg.op_rd;
            s_next.doe = !(s_reg.poll || s_reg.op_rd);
            s_next.dout = s_reg.op_data;
          end
        end
      end
    endcase
  end
  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
      s_reg.st <= H_IDLE;
      s_reg.cs_n <= 1'b1;
      s_reg.rd_n <= 1'b1;
      s_reg.wr_n <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  assign bus.cs_n = s_reg.cs_n;
  assign bus.cd = s_reg.cd;
  assign bus.rd_n = s_reg.rd_n;
  assign bus.wr_n = s_reg.wr_n;
  assign bus.host_dout = s_reg.dout;
  assign bus.host_doe = s_reg.doe;
  assign ack_o = s_reg.ack;
  assign busy_o = (s_reg.st != H_IDLE);
  assign rdata_o = s_reg.rdata;
endmodule : ppc_host

// >>> ppc_bus_monitor.sv
// Purpose: rule checker on the strobed bus between host end and controller end
// Assumes: one clock domain, default strobe and gap lengths of the host end
// Notes: watches interface signals only, instantiated beside the interface
`timescale 1ns/1ps
module ppc_bus_monitor
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus signals
  input wire logic cs_n,
  input wire logic cd,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] host_dout,
  input wire logic host_doe,
  input wire logic [7:0] dev_dout,
  input wire logic dev_doe,
  input wire logic [7:0] data
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [7:0] gap_reg;
  // ****************************************
  // helper logic
  // ****************************************
  // idle cycles before a strobe; saturates so a long pause never wraps
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      gap_reg <= 8'h14;
    else if (!cs_n)
      gap_reg <= 8'h00;
    else if (gap_reg != 8'hFF)
      gap_reg <= gap_reg + 8'h01;
  end
  // ****************************************
  // sequences
  // ****************************************
  sequence wr_low_s;
    (!wr_n && !cs_n && rd_n && host_doe) [*5];
  endsequence
  sequence rd_low_s;
    (!rd_n && !cs_n && wr_n && !host_doe) [*5];
  endsequence
  // second and later cycles of a read, once the registered data settled
  sequence ctl_rd_s;
    dev_doe && $past(dev_doe) && cd && $past(cd);
  endsequence
  sequence prn_rd_s;
    dev_doe && $past(dev_doe) && !cd && !$past(cd);
  endsequence
  // ****************************************
  // assertions
  // ****************************************
  doe_decode_a: assert property (dev_doe == (!cs_n && !rd_n && wr_n))
    else $error("device drive enable does not follow the strobes");
  no_contention_a: assert property (!(host_doe && dev_doe))
    else $error("both ends drive the data bus");
  write_pulse_a: assert property ($fell(wr_n) |-> wr_low_s ##1 (wr_n && !host_doe))
    else $error("write strobe not five cycles with data driven");
  read_pulse_a: assert property ($fell(rd_n) |-> rd_low_s ##1 rd_n)
    else $error("read strobe not five cycles");
  write_hold_a: assert property (!wr_n && !$past(wr_n) |-> $stable(host_dout) && $stable(cd))
    else $error("write data or select moved during strobe");
  recovery_gap_a: assert property ($fell(cs_n) |-> gap_reg >= 8'h14)
    else $error("less than one microsecond between accesses");
  ctl_status_fmt_a: assert property (ctl_rd_s |-> data[7:3] == 5'h00)
    else $error("controller status upper bits not zero");
  prn_status_fmt_a: assert property (prn_rd_s |-> data[7:4] == 4'h0)
    else $error("printer status upper nibble not zero");
  ready_dir_a: assert property (ctl_rd_s ##0 dev_dout[0] |-> !dev_dout[2])
    else $error("status ready while direction shows host writing");
endmodule : ppc_bus_monitor

// >>> printer_controller_host_port_tb.sv
// Purpose: self-checking bench for host end and controller end together
// Assumes: default strobe and gap lengths; the bench plays the mechanism
// Notes: mechanism completion is a one-cycle pulse given when the bench decides
`timescale 1ns/1ps
module printer_controller_host_port_tb
  import ppc_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic head_left_i = 1'b0;
  logic low_paper_i = 1'b0;
  logic left_sense_i = 1'b0;
  logic right_sense_i = 1'b0;
  logic mech_done_i = 1'b0;
  logic [5:0] col_addr_i = 6'h00;
  logic req_i = 1'b0;
  logic rd_i = 1'b0;
  logic cd_i = 1'b0;
  logic check_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic mech_req_o;
  ppc_mop_t mech_op_o;
  logic head_left_o;
  logic [1:0] column_format_field_o;
  logic [1:0] station_select_o;
  logic line_feed_after_print_o;
  logic slip_release_after_print_o;
  logic journal_feed_after_print_o;
  logic receipt_feed_after_print_o;
  logic [1:0] fast_feed_followup_o;
  logic [3:0] step_count_o;
  logic [6:0] col_data_o;
  logic ack_o;
  logic busy_o;
  logic [7:0] rdata_o;
  int err_total = 0;
  int n_checks = 0;
  // ****************************************
  // structure
  // ****************************************
  always #25 clk_i = ~clk_i;
  ppc_bus_if ppc_bus_if_inst ();
  ppc_device ppc_device_inst (.clk_i, .rst_i, .bus(ppc_bus_if_inst), .head_left_i,
    .low_paper_i, .left_sense_i, .right_sense_i, .mech_req_o, .mech_op_o, .mech_done_i,
    .head_left_o, .column_format_field_o, .station_select_o, .line_feed_after_print_o,
    .slip_release_after_print_o, .journal_feed_after_print_o, .receipt_feed_after_print_o,
    .fast_feed_followup_o, .step_count_o, .col_addr_i, .col_data_o);
  ppc_host ppc_host_inst (.clk_i, .rst_i, .bus(ppc_bus_if_inst), .req_i, .rd_i, .cd_i,
    .check_i, .wdata_i, .ack_o, .busy_o, .rdata_o);
  ppc_bus_monitor ppc_bus_monitor_inst (.clk_i, .rst_i, .cs_n(ppc_bus_if_inst.cs_n),
    .cd(ppc_bus_if_inst.cd), .rd_n(ppc_bus_if_inst.rd_n), .wr_n(ppc_bus_if_inst.wr_n),
    .host_dout(ppc_bus_if_inst.host_dout), .host_doe(ppc_bus_if_inst.host_doe),
    .dev_dout(ppc_bus_if_inst.dev_dout), .dev_doe(ppc_bus_if_inst.dev_doe),
    .data(ppc_bus_if_inst.data));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one host request; ack wait is bounded so a dead host cannot hang us
  task automatic xfer(input logic rd, input logic cd, input logic poll, input logic [7:0] wd);
    int n;
    req_i <= 1'b1;
    rd_i <= rd;
    cd_i <= cd;
    check_i <= poll;
    wdata_i <= wd;
    @(posedge clk_i);
    req_i <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
      // host end must leave idle as soon as it takes the request
      if (n == 1)
        chk({7'h00, busy_o}, 8'h01);
    end
    while (ack_o !== 1'b1 && n < 400);
    if (n >= 400)
      chk(8'hEE, 8'hAC);
    else
      chk({7'h00, busy_o}, 8'h00);
  endtask : xfer
  task automatic wc(input logic [7:0] b);
    xfer(1'b0, 1'b1, 1'b1, b);
  endtask : wc
  task automatic wd(input logic [7:0] b);
    xfer(1'b0, 1'b0, 1'b1, b);
  endtask : wd
  task automatic rd_chk(input logic cd, input logic [7:0] exp);
    xfer(1'b1, cd, 1'b0, 8'h00);
    chk(rdata_o, exp);
  endtask : rd_chk
  // buffer port has one cycle of latency; two edges leave it settled
  task automatic col_chk(input logic [5:0] a, input logic [6:0] exp);
    col_addr_i <= a;
    repeat (2) @(posedge clk_i);
    chk({1'b0, col_data_o}, {1'b0, exp});
  endtask : col_chk
  task automatic mech_end();
    chk({7'h00, mech_req_o}, 8'h01);
    mech_done_i <= 1'b1;
    @(posedge clk_i);
    mech_done_i <= 1'b0;
    @(posedge clk_i);
    chk({7'h00, mech_req_o}, 8'h00);
  endtask : mech_end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(1'b1, 8'h04);
    col_chk(6'h27, 7'h20);
    chk({6'h00, column_format_field_o}, 8'h00);
    $display("test reset done");
    wd(8'hC1);
    wd(8'h42);
    wc(8'h73);
    wd(8'h44);
    col_chk(6'h00, 7'h41);
    col_chk(6'h01, 7'h42);
    col_chk(6'h05, 7'h44);
    col_chk(6'h02, 7'h20);
    $display("test data done");
    for (int i = 0; i < 2; i++)
    begin
      {head_left_i, low_paper_i, left_sense_i, right_sense_i} <= (i == 0) ? 4'hA : 4'h5;
      wc(8'h20);
      rd_chk(1'b1, 8'h01);
      xfer(1'b0, 1'b1, 1'b0, 8'h50);
      rd_chk(1'b0, (i == 0) ? 8'h0A : 8'h05);
      rd_chk(1'b1, 8'h04);
      chk({6'h00, column_format_field_o}, 8'h00);
    end
    $display("test status done");
    wc(8'h60);
    wc(8'h7F);
    wc(8'h7F);
    wd(8'h55);
    wd(8'h56);
    col_chk(6'h11, 7'h55);
    // the character after the receipt half lands in the journal half
    col_chk(6'h12, 7'h56);
    for (int f = 2; f >= 0; f--)
    begin
      wc({2'b01, f[1:0], 4'h0});
      chk({6'h00, column_format_field_o}, {6'h00, f[1:0]});
    end
    $display("test format done");
    wc(8'hBC);
    rd_chk(1'b1, 8'h06);
    chk({mech_op_o, station_select_o, journal_feed_after_print_o, receipt_feed_after_print_o,
      line_feed_after_print_o, slip_release_after_print_o}, {MOP_PRINT, 6'h3E});
    xfer(1'b0, 1'b0, 1'b0, 8'h33);
    xfer(1'b0, 1'b1, 1'b0, 8'h50);
    col_chk(6'h00, 7'h41);
    mech_end();
    col_chk(6'h00, 7'h20);
    chk({6'h00, column_format_field_o}, 8'h00);
    wc(8'h85);
    chk({mech_op_o, station_select_o, journal_feed_after_print_o, receipt_feed_after_print_o,
      line_feed_after_print_o, slip_release_after_print_o}, {MOP_PRINT, 6'h07});
    mech_end();
    $display("test print done");
    for (int c = 0; c < 4; c++)
    begin
      wd(8'h58);
      wc({2'b11, c[1:0], c[3:0] + 4'h1});
      chk({mech_op_o, fast_feed_followup_o, step_count_o}, {MOP_FEED, c[1:0], c[3:0] + 4'h1});
      mech_end();
      col_chk(6'h00, 7'h20);
    end
    // polled write during a feed must wait for the end, not be lost
    wc(8'hC0);
    fork
      wd(8'h5A);
      begin
        repeat (60) @(posedge clk_i);
        mech_end();
      end
    join
    col_chk(6'h00, 7'h5A);
    $display("test feed done");
    for (int h = 1; h >= 0; h--)
    begin
      wd(8'h59);
      wc({3'h0, h[0], 4'h0});
      chk({6'h00, mech_op_o}, {6'h00, MOP_INIT});
      chk({7'h00, head_left_o}, {7'h00, h[0]});
      col_chk(6'h00, 7'h20);
      mech_end();
    end
    $display("test init done");
    wrap_up();
  end
  // watchdog: the tests need some 2000 cycles, so 20000 means a hang
  initial
  begin
    #(20000 * 50);
    err_total++;
    wrap_up();
  end
endmodule : printer_controller_host_port_tb
